/* hw/lmc_device.sv */
/*
 * device end: two-wire register slave plus flash, torch, indicator,
 * photo cut-off, picture time-out and thermistor fault control.
 * assumes photo and thermistor levels come from converters in other
 * domains; all outside inputs are synchronised here.
 */
`include "lmc_defines.svh"

module lmc_device
	import lmc_pkg::*;
#(
	parameter int unsigned PICT_TO_CYC = `LMC_PICT_TO_MS * `LMC_CLK_KHZ,
	parameter int unsigned FLASH_CYC = `LMC_FLASH_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	lmc_link_if.dev link,
	// sensing
	input wire logic flashTrigPin,
	input wire logic [7:0] photoLevel,
	input wire logic [7:0] thermLevel,
	// drives
	output logic led1Gate,
	output logic led2Gate,
	output logic led1Mirror,
	output logic led2Mirror,
	output logic led1Indicator,
	output logic chargePumpOn,
	output logic prechargeOn,
	output logic sensorBiasOn,
	output logic thermFault,
	output logic photoCutOff
);

	////////////////////////////////////////////////////////////////////
	logic [1:0] sclS, sdaS, trgS;
	logic sclD, sdaD, trgD;
	logic [7:0] phA, phB, thA, thB;

	always_ff @(posedge clk) begin // see R24
		if (sys_rst) begin
			sclS <= 2'h3;
			sdaS <= 2'h3;
			trgS <= 2'h0;
			sclD <= 1'b1;
			sdaD <= 1'b1;
			trgD <= 1'b0;
			phA <= 8'h00;
			phB <= 8'h00;
			thA <= 8'hff;
			thB <= 8'hff;
		end else begin
			sclS <= {sclS[0], link.scl};
			sdaS <= {sdaS[0], link.sda};
			trgS <= {trgS[0], flashTrigPin};
			sclD <= sclS[1];
			sdaD <= sdaS[1];
			trgD <= trgS[1];
			phA <= photoLevel;
			phB <= phA;
			thA <= thermLevel;
			thB <= thA;
		end
	end

	logic sclRise, sclFall, startSeen, stopSeen;
	assign sclRise = sclS[1] & ~sclD;
	assign sclFall = ~sclS[1] & sclD;
	assign startSeen = sclS[1] & sclD & ~sdaS[1] & sdaD;
	assign stopSeen = sclS[1] & sclD & sdaS[1] & ~sdaD;

	////////////////////////////////////////////////////////////////////
	lmc_dev_st_t st_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r, tx_r, ptr_r, rdVal;
	logic oe_r, nack_r, wrStb_r;
	logic [7:0] ledCfg_r, pumpCfg_r, torch_r, photoThr_r, therm_r;
	logic flashOn_r, photoCut_r, toExp_r, fault_r, torchOn;

	always_comb begin
		case (ptr_r)
			`LMC_REG_LEDCFG: rdVal = ledCfg_r;
			`LMC_REG_PUMPCFG: rdVal = pumpCfg_r;
			`LMC_REG_TORCH: rdVal = torch_r;
			`LMC_REG_PHOTO: rdVal = photoThr_r;
			`LMC_REG_THERM: rdVal = therm_r;
			`LMC_REG_STATUS: rdVal = {3'h0, fault_r, photoCut_r, toExp_r,
				torchOn, flashOn_r};
			default: rdVal = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		wrStb_r <= 1'b0;
		if (sys_rst) begin
			st_r <= DS_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			oe_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (startSeen) begin
			st_r <= DS_ADDR;
			bitCnt_r <= 4'h0;
			oe_r <= 1'b0;
		end else if (stopSeen) begin
			st_r <= DS_IDLE;
			oe_r <= 1'b0;
		end else if (sclRise) begin
			case (st_r)
				DS_ADDR, DS_REG, DS_WDAT: begin
					shift_r <= {shift_r[6:0], sdaS[1]};
					bitCnt_r <= bitCnt_r + 4'h1;
				end
				DS_RD: bitCnt_r <= bitCnt_r + 4'h1;
				DS_MACK: nack_r <= sdaS[1];
				default: ;
			endcase
		end else if (sclFall) begin
			case (st_r)
				DS_ADDR: if (bitCnt_r == 4'h8) begin
					if (shift_r[7:1] == `LMC_DEV_ADDR) begin
						st_r <= DS_AACK;
						oe_r <= 1'b1;
					end else begin
						st_r <= DS_IDLE;
					end
				end
				DS_AACK: begin
					bitCnt_r <= 4'h0;
					if (shift_r[0]) begin
						st_r <= DS_RD;
						tx_r <= rdVal;
						oe_r <= ~rdVal[7];
					end else begin
						st_r <= DS_REG;
						oe_r <= 1'b0;
					end
				end
				DS_REG: if (bitCnt_r == 4'h8) begin // see R6
					ptr_r <= shift_r;
					st_r <= DS_RACK;
					oe_r <= 1'b1;
				end
				DS_RACK, DS_WACK: begin
					st_r <= DS_WDAT;
					bitCnt_r <= 4'h0;
					oe_r <= 1'b0;
				end
				DS_WDAT: if (bitCnt_r == 4'h8) begin
					wrStb_r <= 1'b1;
					st_r <= DS_WACK;
					oe_r <= 1'b1;
				end
				DS_RD: begin
					if (bitCnt_r == 4'h8) begin
						st_r <= DS_MACK;
						oe_r <= 1'b0;
					end else begin
						tx_r <= {tx_r[6:0], 1'b0};
						oe_r <= ~tx_r[6];
					end
				end
				DS_MACK: begin
					bitCnt_r <= 4'h0;
					if (nack_r) begin
						st_r <= DS_IDLE;
					end else begin
						st_r <= DS_RD;
						tx_r <= rdVal;
						oe_r <= ~rdVal[7];
					end
				end
				default: st_r <= DS_IDLE;
			endcase
		end
	end

	assign link.devSdaOe = oe_r;

	////////////////////////////////////////////////////////////////////
	logic flashMode, indicator, flashEnd, trigD_r;
	assign flashMode = pumpCfg_r[`LMC_B_FLSEL]; // see R1
	assign indicator = pumpCfg_r[`LMC_B_IND];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ledCfg_r <= `LMC_REG_RESET;
			pumpCfg_r <= `LMC_REG_RESET;
			torch_r <= `LMC_REG_RESET;
			photoThr_r <= `LMC_REG_RESET;
			therm_r <= `LMC_REG_RESET;
		end else begin
			if (wrStb_r) begin
				case (ptr_r)
					`LMC_REG_LEDCFG: ledCfg_r <= shift_r; // see R5
					`LMC_REG_PUMPCFG: pumpCfg_r <= shift_r;
					`LMC_REG_TORCH: torch_r <= shift_r;
					`LMC_REG_PHOTO: photoThr_r <= shift_r;
					`LMC_REG_THERM: therm_r <= shift_r;
					default: ;
				endcase
			end
			if (flashEnd && !(wrStb_r && ptr_r == `LMC_REG_PUMPCFG))
				pumpCfg_r[`LMC_B_I2CTRG] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	logic fire, photoHit, fromPin_r;
	logic [31:0] flashCnt_r;
	assign fire = flashMode & ~fault_r & ~flashOn_r
		& ((pumpCfg_r[`LMC_B_I2CTRG] & ~trigD_r)
		| (pumpCfg_r[`LMC_B_EXTTRG] & trgS[1] & ~trgD));
	assign photoHit = ledCfg_r[`LMC_B_PHOTO_SENSE_ENABLE] & (phB > photoThr_r); // see R12
	assign flashEnd = flashOn_r & (photoHit | fault_r | ~flashMode
		| (fromPin_r ? ~trgS[1] : (flashCnt_r >= FLASH_CYC - 1))); // see R13

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trigD_r <= 1'b0;
			flashOn_r <= 1'b0;
			fromPin_r <= 1'b0;
			flashCnt_r <= 32'h0;
			photoCut_r <= 1'b0;
		end else begin
			trigD_r <= pumpCfg_r[`LMC_B_I2CTRG];
			if (fire) begin
				flashOn_r <= 1'b1;
				fromPin_r <= ~(pumpCfg_r[`LMC_B_I2CTRG] & ~trigD_r);
				flashCnt_r <= 32'h0;
				photoCut_r <= 1'b0; // see R14
			end else if (flashOn_r) begin
				flashCnt_r <= flashCnt_r + 32'h1;
				if (flashEnd)
					flashOn_r <= 1'b0;
				if (photoHit)
					photoCut_r <= 1'b1; // see R14
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	logic torchReq, toArmed, anyCh;
	logic [31:0] toCnt_r;
	assign anyCh = ledCfg_r[`LMC_B_CH1] | ledCfg_r[`LMC_B_CH2];
	// torch pauses under indicator and yields to any flash
	assign torchReq = ~flashMode & ~indicator & ~fault_r & ~flashOn_r
		& anyCh; // see R9, R11, R18
	assign toArmed = (torch_r > `LMC_TORCH_LIMIT)
		| ledCfg_r[`LMC_B_PLFORCE]; // see R16, R17, R23
	assign torchOn = torchReq & ~(toArmed & toExp_r);

	always_ff @(posedge clk) begin // see R22
		if (sys_rst || flashMode || !anyCh) begin
			toCnt_r <= 32'h0;
			toExp_r <= 1'b0;
		end else if (torchReq && toArmed && !toExp_r) begin // see R7
			toCnt_r <= toCnt_r + 32'h1;
			if (toCnt_r >= PICT_TO_CYC - 1)
				toExp_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	logic clrD_r, faultSet;
	assign faultSet = ledCfg_r[`LMC_B_THEN] & (thB < {1'b0, therm_r[6:0]});

	always_ff @(posedge clk) begin // see R19, R20, R21
		if (sys_rst) begin
			clrD_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			clrD_r <= therm_r[`LMC_B_THCLR];
			if (faultSet)
				fault_r <= 1'b1;
			else if (clrD_r && !therm_r[`LMC_B_THCLR])
				fault_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	logic pumpNow;
	assign pumpNow = pumpCfg_r[`LMC_B_PUMP] & ~fault_r
		& (~flashOn_r | pumpCfg_r[`LMC_B_PUMPFL]); // see R2, R3

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			led1Gate <= 1'b0;
			led2Gate <= 1'b0;
			led1Mirror <= 1'b0;
			led2Mirror <= 1'b0;
			led1Indicator <= 1'b0;
			chargePumpOn <= 1'b0;
			prechargeOn <= 1'b0;
			sensorBiasOn <= 1'b0;
			thermFault <= 1'b0;
			photoCutOff <= 1'b0;
		end else begin
			// gates only during a flash, so indicator alone leaves them off
			led1Gate <= flashOn_r & ledCfg_r[`LMC_B_CH1]; // see R10
			led2Gate <= flashOn_r & ledCfg_r[`LMC_B_CH2];
			led1Mirror <= torchOn & ledCfg_r[`LMC_B_CH1];
			led2Mirror <= torchOn & ledCfg_r[`LMC_B_CH2];
			led1Indicator <= indicator; // see R8, R11
			chargePumpOn <= pumpNow;
			prechargeOn <= pumpCfg_r[`LMC_B_PRECH] & ~fault_r; // see R4
			sensorBiasOn <= pumpNow | ledCfg_r[`LMC_B_PHBIAS]; // see R15
			thermFault <= fault_r;
			photoCutOff <= photoCut_r;
		end
	end

endmodule : lmc_device

/* hw/lmc_defines.svh */
/*
 * constants of the flash LED mode controller: register indices, field
 * positions, reset values and timing counts shared by both ends.
 * assumes a 200 MHz clk and an I2C style two-wire link between the ends.
 */
// Summary of operation
// R1 - mode bit low selects torch/video mode
// R2 - pump-during-flash bit keeps pump on in pulse
// R3 - pump enable bit switches charge pump
// R4 - precharge enable bit switches precharge
// R5 - channel bits enable LED one and two
// R6 - host selects channel register index one first
// R7 - indicator mode ignores width, disables time-out
// R8 - indicator drives only LED channel one
// R9 - torch suspended while indicator on, then resumes
// R10 - indicator forces gate drives off, mirror current
// R11 - flash and torch outrank indicator, currents add; torch here pauses while indicator on
// R12 - photo sense enable shortens flash
// R13 - flash ends when sensor exceeds threshold
// R14 - one cut-off per flash, re-armed by trigger
// R15 - sensor bias on with pump or bias bit
// R16 - picture time-out armed above torch limit
// R17 - force bit arms picture time-out always
// R18 - no picture light during flash pulse
// R19 - thermistor enable compares against threshold
// R20 - low thermistor voltage latches fault, outputs off; here led1Indicator and sensorBiasOn from the bias bit stay on
// R21 - fault cleared by reset or clear pulse
// R22 - torch mode ignores width, no flash time-out
// R23 - torch level above 3f arms time-out
// R24 - latches and priority are synchronous logic
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH

`define LMC_DEV_ADDR 7'h3e
`define LMC_REG_LEDCFG 8'h01
`define LMC_REG_PUMPCFG 8'h02
`define LMC_REG_TORCH 8'h05
`define LMC_REG_PHOTO 8'h06
`define LMC_REG_THERM 8'h09
`define LMC_REG_STATUS 8'h17
`define LMC_REG_RESET 8'h00

// led channel config fields
`define LMC_B_CH1 0
`define LMC_B_CH2 1
`define LMC_B_PHBIAS 2
`define LMC_B_PLFORCE 3
`define LMC_B_PHOTO_SENSE_ENABLE 5
`define LMC_B_THEN 6
// pump and mode config fields
`define LMC_B_PRECH 1
`define LMC_B_PUMP 2
`define LMC_B_EXTTRG 3
`define LMC_B_I2CTRG 4
`define LMC_B_FLSEL 5
`define LMC_B_PUMPFL 6
`define LMC_B_IND 7
// thermistor threshold fields
`define LMC_B_THCLR 7
`define LMC_TORCH_LIMIT 8'h3f

`define LMC_CLK_KHZ 200000
`define LMC_PICT_TO_MS 200
`define LMC_FLASH_CYC 1000
`define LMC_QTR_CYC 25

`define LMC_APB_CMD 12'h000
`define LMC_APB_STAT 12'h004

`endif

/* hw/lmc_pkg.sv */
/*
 * types of the flash LED mode controller.
 * assumes lmc_defines.svh is on the include path.
 */
package lmc_pkg;
	typedef enum logic [8:0] {
		DS_IDLE = 9'b000000001,
		DS_ADDR = 9'b000000010,
		DS_AACK = 9'b000000100,
		DS_REG = 9'b000001000,
		DS_RACK = 9'b000010000,
		DS_WDAT = 9'b000100000,
		DS_WACK = 9'b001000000,
		DS_RD = 9'b010000000,
		DS_MACK = 9'b100000000
	} lmc_dev_st_t;

	typedef enum logic [4:0] {
		IT_START = 5'b00001,
		IT_WR = 5'b00010,
		IT_RD = 5'b00100,
		IT_STOP = 5'b01000,
		IT_END = 5'b10000
	} lmc_item_t;
endpackage : lmc_pkg

/* hw/lmc_link_if.sv */
/*
 * two-wire link between host and device end.
 * both lines are open drain: the interface resolves them with pull-ups.
 */
interface lmc_link_if;
	logic hostSclOe;
	logic hostSdaOe;
	logic devSdaOe;
	logic scl;
	logic sda;

	assign scl = ~hostSclOe;
	assign sda = ~(hostSdaOe | devSdaOe);

	modport dev (input scl, input sda, output devSdaOe);
	modport host (input sda, output hostSclOe, output hostSdaOe);
endinterface : lmc_link_if

/* hw/lmc_host.sv */
/*
 * host end: APB slave command registers driving a two-wire master that
 * writes or reads one device register per command.
 * assumes APB on the same clk; the device never stretches the clock.
 */
`include "lmc_defines.svh"

module lmc_host
	import lmc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link
	lmc_link_if.host link
);

	////////////////////////////////////////////////////////////////////
	logic busy_r, nack_r, cmdRd_r, go;
	logic [7:0] rdData_r, cmdReg_r, cmdData_r;
	logic acc;
	assign acc = psel & penable & ~pready;
	assign go = acc & pwrite & (paddr == `LMC_APB_CMD) & ~busy_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			cmdRd_r <= 1'b0;
			cmdReg_r <= 8'h00;
			cmdData_r <= 8'h00;
		end else begin
			pready <= acc;
			pslverr <= acc & (paddr != `LMC_APB_CMD)
				& (paddr != `LMC_APB_STAT);
			prdata <= 32'h0;
			if (acc && !pwrite && paddr == `LMC_APB_STAT)
				prdata <= {16'h0, rdData_r, 6'h0, nack_r, busy_r};
			if (go) begin // see R6
				cmdData_r <= pwdata[7:0];
				cmdReg_r <= pwdata[15:8];
				cmdRd_r <= pwdata[16];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	logic [3:0] idx_r, bit_r;
	logic [1:0] q_r, sdaS;
	logic [7:0] div_r, itemByte;
	logic tick, sclOe_r, sdaOe_r;
	lmc_item_t item;
	assign tick = (div_r == 8'(`LMC_QTR_CYC - 1));

	always_comb begin
		itemByte = 8'h00;
		item = IT_END;
		case (idx_r)
			4'h0: item = IT_START;
			4'h1: begin
				item = IT_WR;
				itemByte = {`LMC_DEV_ADDR, 1'b0};
			end
			4'h2: begin
				item = IT_WR;
				itemByte = cmdReg_r;
			end
			4'h3: begin
				item = cmdRd_r ? IT_STOP : IT_WR;
				itemByte = cmdData_r;
			end
			4'h4: item = cmdRd_r ? IT_START : IT_STOP;
			4'h5: begin
				item = cmdRd_r ? IT_WR : IT_END;
				itemByte = {`LMC_DEV_ADDR, 1'b1};
			end
			4'h6: item = cmdRd_r ? IT_RD : IT_END;
			4'h7: item = cmdRd_r ? IT_STOP : IT_END;
			default: item = IT_END;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sdaS <= 2'h3;
			div_r <= 8'h00;
		end else begin
			sdaS <= {sdaS[0], link.sda};
			div_r <= (tick || !busy_r) ? 8'h00 : div_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			nack_r <= 1'b0;
			rdData_r <= 8'h00;
			idx_r <= 4'h0;
			bit_r <= 4'h0;
			q_r <= 2'h0;
			sclOe_r <= 1'b0;
			sdaOe_r <= 1'b0;
		end else if (go) begin
			busy_r <= 1'b1;
			nack_r <= 1'b0;
			idx_r <= 4'h0;
			bit_r <= 4'h0;
			q_r <= 2'h0;
		end else if (busy_r && tick) begin
			q_r <= q_r + 2'h1;
			case (item)
				IT_START: case (q_r)
					2'h0: begin
						sclOe_r <= 1'b0;
						sdaOe_r <= 1'b0;
					end
					2'h1: sdaOe_r <= 1'b1;
					2'h2: sclOe_r <= 1'b1;
					default: idx_r <= idx_r + 4'h1;
				endcase
				IT_WR, IT_RD: case (q_r)
					2'h0: sdaOe_r <= (item == IT_WR) && (bit_r < 4'h8)
						&& !itemByte[3'(4'h7 - bit_r)];
					2'h1: sclOe_r <= 1'b0;
					2'h2: begin
						if (bit_r < 4'h8 && item == IT_RD)
							rdData_r <= {rdData_r[6:0], sdaS[1]};
						if (bit_r == 4'h8 && item == IT_WR && sdaS[1])
							nack_r <= 1'b1;
					end
					default: begin
						sclOe_r <= 1'b1;
						bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
						if (bit_r == 4'h8)
							idx_r <= idx_r + 4'h1;
					end
				endcase
				IT_STOP: case (q_r)
					2'h0: begin
						sclOe_r <= 1'b1;
						sdaOe_r <= 1'b1;
					end
					2'h1: sclOe_r <= 1'b0;
					2'h2: sdaOe_r <= 1'b0;
					default: idx_r <= idx_r + 4'h1;
				endcase
				default: begin
					busy_r <= 1'b0;
					sclOe_r <= 1'b0;
					sdaOe_r <= 1'b0;
				end
			endcase
		end
	end

	assign link.hostSclOe = sclOe_r;
	assign link.hostSdaOe = sdaOe_r;

endmodule : lmc_host

/* tb/lmc_link_properties.sv */
/*
 * link checker: timing relations on the two-wire link between the ends.
 * assumes it is instantiated beside the link interface, on the same clk.
 */
module lmc_link_properties (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link
	input wire logic hostSclOe,
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	a_rst_host_idle: assert property (
		$fell(sys_rst) |-> !hostSclOe && !hostSdaOe)
		else $error("host drives link after reset");
	a_rst_dev_idle: assert property (
		$fell(sys_rst) |-> !devSdaOe)
		else $error("device drives link after reset");
	a_dev_sda_stable: assert property (
		scl && $past(scl) |-> $stable(devSdaOe))
		else $error("device data moved while clock high");
	a_dev_drive_lag: assert property (
		$rose(devSdaOe) |-> !scl && !$past(scl, 2))
		else $error("device drove data too soon after clock fall");
	a_dev_drive_bound: assert property (
		$rose(devSdaOe) |-> ##[1:1000] !devSdaOe)
		else $error("device holds data line too long");
	a_dev_no_start: assert property (
		$fell(sda) && scl |-> !devSdaOe)
		else $error("device made a start condition");
	a_scl_low_min: assert property (
		$fell(scl) |-> !scl [*8])
		else $error("clock low phase too short");
	a_scl_high_min: assert property (
		$rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	a_scl_low_max: assert property (
		$fell(scl) |-> ##[1:150] scl)
		else $error("clock stuck low");

	c_dev_ack: cover property ($rose(devSdaOe));
	c_start: cover property ($fell(sda) && scl);
	c_stop: cover property ($rose(sda) && scl);
endmodule : lmc_link_properties

/* tb/lmc_tb_top.sv */
/*
 * testbench: host and device joined by the link, driven over APB.
 * assumes the design files and the link checker are compiled first.
 */
`include "lmc_defines.svh"

module lmc_tb_top
	import lmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic flashTrigPin = 1'b0;
	logic [7:0] photoLevel = 8'h00;
	logic [7:0] thermLevel = 8'hff;
	logic led1Gate, led2Gate, led1Mirror, led2Mirror, led1Indicator;
	logic chargePumpOn, prechargeOn, sensorBiasOn, thermFault, photoCutOff;
	logic [9:0] outs;
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int total_checks = 0;

	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	lmc_link_if link ();
	lmc_host i_lmc_host (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link.host));
	lmc_device #(.PICT_TO_CYC(200), .FLASH_CYC(50)) i_lmc_device (
		.clk(clk), .sys_rst(sys_rst), .link(link.dev),
		.flashTrigPin(flashTrigPin), .photoLevel(photoLevel),
		.thermLevel(thermLevel), .led1Gate(led1Gate), .led2Gate(led2Gate),
		.led1Mirror(led1Mirror), .led2Mirror(led2Mirror),
		.led1Indicator(led1Indicator), .chargePumpOn(chargePumpOn),
		.prechargeOn(prechargeOn), .sensorBiasOn(sensorBiasOn),
		.thermFault(thermFault), .photoCutOff(photoCutOff));
	lmc_link_properties i_lmc_link_properties (.clk(clk), .sys_rst(sys_rst),
		.hostSclOe(link.hostSclOe), .hostSdaOe(link.hostSdaOe),
		.devSdaOe(link.devSdaOe), .scl(link.scl), .sda(link.sda));

	assign outs = {led1Gate, led2Gate, led1Mirror, led2Mirror, led1Indicator,
		chargePumpOn, prechargeOn, sensorBiasOn, thermFault, photoCutOff};

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chko(input logic [9:0] m, input logic [9:0] e);
		chk({22'h0, outs & m}, {22'h0, e});
	endtask : chko

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one register command over the link, then wait for busy to drop
	task automatic cmd(input logic rdn, input logic [7:0] idx,
		input logic [7:0] d);
		apb(1'b1, `LMC_APB_CMD, {15'h0, rdn, idx, d});
		do
			apb(1'b0, `LMC_APB_STAT, 32'h0);
		while (rd[0] !== 1'b0);
	endtask : cmd

	task automatic settle;
		repeat (8) @(posedge clk);
	endtask : settle

	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge clk);
		failures++;
		$display("Error at %0t: timeout", $time);
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		cmd(1'b0, `LMC_REG_LEDCFG, 8'h03);
		cmd(1'b0, `LMC_REG_PUMPCFG, 8'h06);
		chko(10'h3ff, 10'h0dc);
		cmd(1'b0, `LMC_REG_PUMPCFG, 8'h86);
		chko(10'h3ff, 10'h03c);
		cmd(1'b0, `LMC_REG_PUMPCFG, 8'h06);
		chko(10'h3ff, 10'h0dc);
		// thermistor fault latch
		cmd(1'b0, `LMC_REG_THERM, 8'h40);
		cmd(1'b0, `LMC_REG_LEDCFG, 8'h47);
		chko(10'h0f6, 10'h0d4);
		thermLevel <= 8'h10;
		settle();
		// bias bit alone keeps the sensor bias with the pump off
		chko(10'h0f6, 10'h006);
		thermLevel <= 8'hff;
		settle();
		chko(10'h0f6, 10'h006);
		cmd(1'b0, `LMC_REG_THERM, 8'hc0);
		cmd(1'b0, `LMC_REG_THERM, 8'h40);
		chko(10'h0f6, 10'h0d4);
		// pin flash with photo cut-off
		cmd(1'b0, `LMC_REG_LEDCFG, 8'h23);
		cmd(1'b0, `LMC_REG_PHOTO, 8'h80);
		cmd(1'b0, `LMC_REG_PUMPCFG, 8'h2e);
		chko(10'h3e3, 10'h000);
		flashTrigPin <= 1'b1;
		settle();
		chko(10'h3f1, 10'h300);
		photoLevel <= 8'hff;
		settle();
		chko(10'h301, 10'h001);
		photoLevel <= 8'h00;
		settle();
		chko(10'h301, 10'h001);
		flashTrigPin <= 1'b0;
		settle();
		chko(10'h310, 10'h010);
		flashTrigPin <= 1'b1;
		settle();
		chko(10'h301, 10'h300);
		photoLevel <= 8'hff;
		settle();
		chko(10'h301, 10'h001);
		photoLevel <= 8'h00;
		flashTrigPin <= 1'b0;
		// timed flash from the trigger bit re-arms the cut-off
		cmd(1'b0, `LMC_REG_PUMPCFG, 8'h7e);
		chko(10'h301, 10'h000);
		// trigger bit drops once the timed flash is over
		cmd(1'b1, `LMC_REG_PUMPCFG, 8'h00);
		chk({24'h0, rd[15:8]}, 32'h0000006e);
		// pump kept running through a pin flash
		flashTrigPin <= 1'b1;
		settle();
		chko(10'h311, 10'h310);
		flashTrigPin <= 1'b0;
		// picture light time-out
		cmd(1'b0, `LMC_REG_PUMPCFG, 8'h06);
		cmd(1'b0, `LMC_REG_TORCH, 8'h40);
		repeat (300) @(posedge clk);
		chko(10'h0c0, 10'h000);
		cmd(1'b1, `LMC_REG_STATUS, 8'h00);
		chk({31'h0, rd[10]}, 32'h1);
		cmd(1'b0, `LMC_REG_TORCH, 8'h3f);
		cmd(1'b0, `LMC_REG_LEDCFG, 8'h00);
		cmd(1'b0, `LMC_REG_LEDCFG, 8'h03);
		repeat (400) @(posedge clk);
		chko(10'h0c0, 10'h0c0);
		cmd(1'b0, `LMC_REG_LEDCFG, 8'h0b);
		repeat (300) @(posedge clk);
		chko(10'h0c0, 10'h000);
		report_and_stop();
	end
endmodule : lmc_tb_top
